// ---- bench/encoder_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module encoder_model (
    // Clock
    input  wire logic       clk,
    // Tracks per channel and index of channel 0
    output var  logic [1:0] a,
    output var  logic [1:0] b,
    output var  logic       c
);
    logic [1:0] ph [2];
    // Pins idle low, shaft at phase zero
    initial begin
        a = 2'h0;
        b = 2'h0;
        c = 1'b0;
        ph[0] = 2'h0;
        ph[1] = 2'h0;
    end
    // Gray steps, A leads B going up; one track pin moves per step
    task automatic step(input int ch, input bit up, input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            ph[ch] = up ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
            a[ch] <= ph[ch][1] ^ ph[ch][0];
            b[ch] <= ph[ch][1];
            c <= (ph[0] == 2'h0);
        end
    endtask
    // Single-track pulses on A of channel 0, B level sets direction
    task automatic pulse(input bit up, input int half, input int n);
        @(posedge clk);
        a[0] <= 1'b0;
        b[0] <= !up;
        repeat (n) begin
            repeat (half) @(posedge clk);
            a[0] <= 1'b1;
            repeat (half) @(posedge clk);
            a[0] <= 1'b0;
        end
    endtask
endmodule // encoder_model
`default_nettype wire

// ---- bench/quadrature_encoder_counter_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module quadrature_encoder_counter_sva (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RSTN,
    // Register bus
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Cycle events and marker
    input wire logic        FRAME_EVENT,
    input wire logic        SYNC_OUT_EVENT,
    input wire logic        SYNC_IN_EVENT,
    input wire logic        CYCLE_START
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // Decoded bus phase and address class
    logic setup;
    logic bad_adr;
    logic any_ev;
    assign setup   = PSEL && !PENABLE;
    assign bad_adr = (PADDR > 8'h40) || (PADDR[1:0] != 2'h0);
    assign any_ev  = FRAME_EVENT || SYNC_OUT_EVENT || SYNC_IN_EVENT;

    a_ready_follows: assert property (setup |=> PREADY)
        else $error("no ready after setup");
    a_ready_cause: assert property (PREADY |-> $past(setup))
        else $error("ready without setup");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_err_bad_addr: assert property (setup && bad_adr |=> PSLVERR)
        else $error("unmapped address not refused");
    a_err_good_addr: assert property (setup && !bad_adr |=> !PSLVERR)
        else $error("mapped address refused");
    a_err_zero_data: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
        else $error("refused read returns data");
    a_data_holds: assert property (!setup |=> $stable(PRDATA))
        else $error("read data moved outside access");
    a_start_cause: assert property (CYCLE_START |-> $past(any_ev))
        else $error("cycle start without event");
    a_start_single: assert property (CYCLE_START && !any_ev |=> !CYCLE_START)
        else $error("cycle start too long");
endmodule // quadrature_encoder_counter_sva

bind quadrature_encoder_counter quadrature_encoder_counter_sva i_sva (
    .MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FRAME_EVENT(FRAME_EVENT),
    .SYNC_OUT_EVENT(SYNC_OUT_EVENT), .SYNC_IN_EVENT(SYNC_IN_EVENT),
    .CYCLE_START(CYCLE_START));
`default_nettype wire

// ---- bench/quadrature_encoder_counter_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module quadrature_encoder_counter_tb;
    import quadrature_encoder_counter_pkg::*;
    logic        mclk, rstn, psel, penable, pwrite, pready, pslverr;
    logic        gate, cyc, enc_c, perr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [2:0]  ev;
    logic [1:0]  enc_a, enc_b;
    logic [63:0] dc_time;
    int          bad_count, checks_done;

    // Short period limits keep saturation reachable in a short run
    quadrature_encoder_counter #(.PERIOD_SHORT_LIMIT(50),
        .PERIOD_LONG_LIMIT(100), .FREQ_WINDOW(64)) i_dut (
        .MCLK(mclk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .ENC_A(enc_a), .ENC_B(enc_b),
        .ENC0_C(enc_c), .GATE_IN(gate), .FRAME_EVENT(ev[0]),
        .SYNC_OUT_EVENT(ev[1]), .SYNC_IN_EVENT(ev[2]), .DC_TIME(dc_time),
        .CYCLE_START(cyc));
    encoder_model i_enc (.clk(mclk), .a(enc_a), .b(enc_b), .c(enc_c));

    // Clock and free-running time base
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) dc_time <= dc_time + 64'h1;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus transfer; request held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] adr,
                       input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        apb(1'b0, adr, 32'h0);
        chk(rdat, exp);
    endtask
    // Pulse one cycle event after letting pin changes settle
    task automatic evt(input int k);
        repeat (6) @(posedge mclk);
        ev <= 3'(3'b001 << k);
        @(posedge mclk);
        ev <= 3'b000;
        #1;
    endtask
    task automatic results;
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        results;
    end

    // Main sequence
    initial begin
        {rstn, psel, penable, pwrite, gate, ev} = 8'h00;
        {paddr, pwdata, dc_time} = '0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(OFS_CONFIG, 32'h0);
        rd(OFS_LAYOUT_ACT, 32'h0);
        apb(1'b0, 8'h44, 32'h0);
        chk(32'(perr), 32'h1);
        i_enc.step(0, 1'b1, 6);
        i_enc.step(1, 1'b0, 3);
        evt(0);
        rd(OFS_COUNT0, 32'h6);
        rd(OFS_COUNT1, 32'hfffffffd);
        apb(1'b1, OFS_PRESET0, 32'h0001fffe);
        apb(1'b1, OFS_CTRL0, 32'h1);
        evt(0);
        evt(0);
        rd(OFS_COUNT0, 32'h0001fffe);
        chk(rdat, 32'h0001fffe);
        apb(1'b1, OFS_CTRL0, 32'h0);
        // Width change waits for reload, then wraps at 16 bits
        apb(1'b1, OFS_LAYOUT_PEND, 32'h1);
        rd(OFS_LAYOUT_ACT, 32'h0);
        apb(1'b1, OFS_RELOAD, 32'h1);
        rd(OFS_LAYOUT_ACT, 32'h1);
        i_enc.step(0, 1'b1, 3);
        evt(0);
        rd(OFS_COUNT0, 32'h1);
        // Both halting gate modes freeze the count
        apb(1'b1, OFS_CONFIG, 32'h1);
        @(posedge mclk);
        gate <= 1'b1;
        i_enc.step(0, 1'b1, 2);
        apb(1'b1, OFS_CONFIG, 32'h2);
        @(posedge mclk);
        gate <= 1'b0;
        i_enc.step(0, 1'b1, 2);
        evt(0);
        rd(OFS_COUNT0, 32'h1);
        apb(1'b1, OFS_CONFIG, 32'h4);
        i_enc.pulse(1'b1, 4, 4);
        i_enc.pulse(1'b0, 4, 1);
        evt(0);
        rd(OFS_COUNT0, 32'h4);
        // Latch on gate rising edge
        apb(1'b1, OFS_CONFIG, 32'h7);
        apb(1'b1, OFS_CTRL0, 32'h2);
        @(posedge mclk);
        gate <= 1'b1;
        evt(0);
        rd(OFS_LATCH0, 32'h4);
        rd(OFS_STATUS0, 32'h6);
        chk(rdat & 32'h2, 32'h2);
        // Period option, 20 cycles between rising edges of A
        apb(1'b1, OFS_LAYOUT_PEND, 32'h3);
        apb(1'b1, OFS_RELOAD, 32'h1);
        i_enc.pulse(1'b1, 10, 3);
        evt(0);
        rd(OFS_OPT0, 32'd20);
        rd(OFS_COUNT0, 32'h7);
        // Each cycle mode answers its own event only
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, OFS_LAYOUT_PEND, 32'h3 | 32'(m << 5));
            apb(1'b1, OFS_RELOAD, 32'h1);
            for (int e = 0; e < 3; e++) begin
                evt(e);
                chk(32'(cyc), 32'(e == m));
            end
        end
        results;
    end
endmodule // quadrature_encoder_counter_tb
`default_nettype wire

// ---- core/encoder_channel.sv ----
`timescale 1ns/100ps
`default_nettype none
module encoder_channel
    import quadrature_encoder_counter_pkg::*;
#(
    parameter int PERIOD_SHORT_LIMIT = PERIOD_SHORT_UNITS,
    parameter int PERIOD_LONG_LIMIT  = PERIOD_LONG_UNITS,
    parameter int FREQ_WINDOW        = FREQ_WINDOW_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Raw encoder pins
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    // Control
    input  wire logic        hold,
    input  wire logic        single_track,
    input  wire logic        width16,
    input  wire logic        period_long,
    input  wire logic        load,
    input  wire logic [31:0] load_value,
    // Live results
    output var  chan_out_t   result
);

    typedef struct packed {
        logic        a_s1;
        logic        a_s2;
        logic        a_q;
        logic        b_s1;
        logic        b_s2;
        logic        b_q;
        logic [31:0] count;
        logic [7:0]  unit_cnt;
        logic [31:0] per_cnt;
        logic [31:0] period;
        logic        over;
        logic [31:0] win_cnt;
        logic [31:0] edges;
        logic [31:0] freq;
        logic        inc;
    } chan_state_t;

    localparam logic [7:0] UNIT_LAST = 8'(PERIOD_UNIT_CYCLES - 1);

    chan_state_t st_ff;
    chan_state_t nxt_st;
    logic        a_rise;
    logic        step;
    logic        up;
    logic        unit_tick;
    logic        win_end;
    logic [31:0] mask;
    logic [31:0] limit;

    // Decode, count, period and frequency in one pass
    always_comb begin
        nxt_st = st_ff;
        nxt_st.a_s1 = enc_a;
        nxt_st.a_s2 = st_ff.a_s1;
        nxt_st.a_q  = st_ff.a_s2;
        nxt_st.b_s1 = enc_b;
        nxt_st.b_s2 = st_ff.b_s1;
        nxt_st.b_q  = st_ff.b_s2;
        a_rise = st_ff.a_s2 & ~st_ff.a_q;
        if (single_track) begin
            step = a_rise;                                      // R6
            up   = ~st_ff.b_s2;                                 // R6
        end else begin
            // One track changing at a time is a valid quadrature step
            step = (st_ff.a_s2 ^ st_ff.a_q) ^ (st_ff.b_s2 ^ st_ff.b_q); // R19
            up   = st_ff.a_s2 ^ st_ff.b_q;                      // R19
        end
        mask = width16 ? MASK16 : MASK32;                       // R1
        nxt_st.inc = 1'b0;
        if (load) begin
            nxt_st.count = load_value & mask;                   // R1
        end else if (step && !hold) begin
            nxt_st.count = (up ? st_ff.count + 32'h1
                               : st_ff.count - 32'h1) & mask;   // R20
            nxt_st.inc = 1'b1;
        end
        // Period in 100 ns units, pinned at the selected range
        limit = period_long ? 32'(PERIOD_LONG_LIMIT)
                            : 32'(PERIOD_SHORT_LIMIT);          // R8
        unit_tick = (st_ff.unit_cnt == UNIT_LAST);
        nxt_st.unit_cnt = unit_tick ? 8'h00 : st_ff.unit_cnt + 8'h01;
        if (unit_tick && st_ff.per_cnt < limit) begin
            nxt_st.per_cnt = st_ff.per_cnt + 32'h1;             // R7
        end
        if (a_rise) begin
            // Include the unit that closes at this very edge
            nxt_st.period   = nxt_st.per_cnt;                   // R7
            nxt_st.over     = (nxt_st.per_cnt >= limit);        // R8
            nxt_st.per_cnt  = 32'h0;
            nxt_st.unit_cnt = 8'h00;
        end
        // Rising edges of track A per window give the frequency
        win_end = (st_ff.win_cnt == 32'(FREQ_WINDOW - 1));
        nxt_st.win_cnt = win_end ? 32'h0 : st_ff.win_cnt + 32'h1;
        nxt_st.edges = st_ff.edges + {31'h0, a_rise};
        if (win_end) begin
            nxt_st.freq  = st_ff.edges + {31'h0, a_rise};       // R14
            nxt_st.edges = 32'h0;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Results straight from the state register, in struct field order
    assign result = {st_ff.count, st_ff.period, st_ff.over, st_ff.freq,
                     st_ff.inc};

endmodule // encoder_channel
`default_nettype wire

// ---- core/quadrature_encoder_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: Position counter readable and presettable, 32 bits or reduced to 16 bits.
// R2: Counter fed by quadrature decoder on tracks A and B; channel 0 has latch.
// R3: Two independent 32-bit counters, one per encoder channel, own image data.
// R4: Gate/latch input captures channel 0 count when configured for latching.
// R5: Gate input mode: none, halt counting while high, halt while low.
// R6: Single-track mode counts track A pulses, track B level sets direction. Code applies it to channel 0 only.
// R7: Time between rising edges of track A reported in 100 ns units.
// R8: Period range ends at 1.6 s or 3.2 s by configuration.
// R9: Frame-triggered mode starts each cycle on the frame arrival event.
// R10: Clock-synchronous mode starts cycles on the output-aligned clock event.
// R11: Input-aligned mode starts cycles on the input-aligned clock event.
// R12: Input image: status, counter, latch; 32 or 16 bits per layout.
// R13: Output image: control bits and preset value, 32 or 16 bits per layout.
// R14: Each channel optionally adds a 32-bit frequency or period value.
// R15: Optional 32 or 64-bit timestamp of last counted edge of channel 0.
// R16: Counter, latch and preset values sit at fixed register locations.
// R17: Online configuration writes act at once.
// R18: Layout changes act only after a reload command from the master.
// R19: Quadrature decoder counts every edge of both tracks, direction by phase.
// R20: Counter wraps modulo its configured width, never saturates.
module quadrature_encoder_counter
    import quadrature_encoder_counter_pkg::*;
#(
    parameter int PERIOD_SHORT_LIMIT = PERIOD_SHORT_UNITS,
    parameter int PERIOD_LONG_LIMIT  = PERIOD_LONG_UNITS,
    parameter int FREQ_WINDOW        = FREQ_WINDOW_CYCLES
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    // Encoder pins, index 0 and 1 are the two channels
    input  wire logic [1:0]  ENC_A,
    input  wire logic [1:0]  ENC_B,
    input  wire logic        ENC0_C,
    input  wire logic        GATE_IN,
    // Cycle events and distributed clock time, same clock domain
    input  wire logic        FRAME_EVENT,
    input  wire logic        SYNC_OUT_EVENT,
    input  wire logic        SYNC_IN_EVENT,
    input  wire logic [63:0] DC_TIME,
    // Cycle marker
    output var  logic        CYCLE_START
);

    typedef struct packed {
        config_t               cfg;
        layout_t               lay_pend;
        layout_t               lay_act;
        ctrl_t   [1:0]         ctrl;
        logic    [1:0][31:0]   preset;
        logic    [1:0]         set_done;
        logic    [1:0]         load;
        logic                  latch_valid;
        logic    [31:0]        latch_live;
        logic    [63:0]        ts_live;
        logic                  gate_s1;
        logic                  gate_s2;
        logic                  gate_q;
        logic                  idx_s1;
        logic                  idx_s2;
        status_t [1:0]         status_img;
        logic    [1:0][31:0]   cnt_img;
        logic    [31:0]        latch_img;
        logic    [1:0][31:0]   opt_img;
        logic    [63:0]        ts_img;
        logic                  cyc;
        logic    [31:0]        prdata;
        logic                  pready;
        logic                  pslverr;
    } top_state_t;

    top_state_t  st_ff;
    top_state_t  nxt_st;
    chan_out_t   ch_out [0:1];
    logic [1:0]  hold;
    logic        gate_rise;
    logic        cyc_start;
    logic [31:0] mask;
    logic        setup;
    logic        access;
    logic [31:0] rdata;
    logic        hit;

    // Gate halts only channel 0; the second channel has no gate input
    assign hold[0] = (st_ff.cfg.gate_mode == GATE_HALT_HIGH && st_ff.gate_s2)
                  || (st_ff.cfg.gate_mode == GATE_HALT_LOW && !st_ff.gate_s2); // R5
    assign hold[1] = 1'b0;

    // One decoder per encoder channel
    for (genvar gi = 0; gi < 2; gi++) begin : g_chan
        encoder_channel #(
            .PERIOD_SHORT_LIMIT (PERIOD_SHORT_LIMIT),
            .PERIOD_LONG_LIMIT  (PERIOD_LONG_LIMIT),
            .FREQ_WINDOW        (FREQ_WINDOW)
        ) u_chan (
            .clk          (MCLK),
            .rst_n        (RSTN),
            .enc_a        (ENC_A[gi]),
            .enc_b        (ENC_B[gi]),
            .hold         (hold[gi]),
            .single_track (st_ff.cfg.single_track && gi == 0),
            .width16      (st_ff.lay_act.width16),
            .period_long  (st_ff.cfg.period_long),
            .load         (st_ff.load[gi]),
            .load_value   (st_ff.preset[gi]),
            .result       (ch_out[gi])
        ); // R3
    end

    // Register read decode, captured in the setup phase
    always_comb begin
        rdata = 32'h0;
        hit   = 1'b1;
        case (PADDR)
            OFS_CONFIG:      rdata = {28'h0, st_ff.cfg};
            OFS_LAYOUT_PEND: rdata = {25'h0, st_ff.lay_pend};
            OFS_LAYOUT_ACT:  rdata = {25'h0, st_ff.lay_act};
            OFS_RELOAD:      rdata = 32'h0;
            OFS_CTRL0:       rdata = {30'h0, st_ff.ctrl[0]};
            OFS_PRESET0:     rdata = st_ff.preset[0];        // R16
            OFS_CTRL1:       rdata = {30'h0, st_ff.ctrl[1]};
            OFS_PRESET1:     rdata = st_ff.preset[1];
            OFS_STATUS0:     rdata = {27'h0, st_ff.status_img[0]};
            OFS_COUNT0:      rdata = st_ff.cnt_img[0];       // R16
            OFS_LATCH0:      rdata = st_ff.latch_img;        // R16
            OFS_OPT0:        rdata = st_ff.opt_img[0];
            OFS_TS_LO:       rdata = st_ff.ts_img[31:0];
            OFS_TS_HI:       rdata = st_ff.ts_img[63:32];
            OFS_STATUS1:     rdata = {27'h0, st_ff.status_img[1]};
            OFS_COUNT1:      rdata = st_ff.cnt_img[1];
            OFS_OPT1:        rdata = st_ff.opt_img[1];
            default:         hit   = 1'b0;
        endcase
    end

    // Next state of the whole block
    always_comb begin
        nxt_st = st_ff;
        // Two-stage synchronisers for the gate and index pins
        nxt_st.gate_s1 = GATE_IN;
        nxt_st.gate_s2 = st_ff.gate_s1;
        nxt_st.gate_q  = st_ff.gate_s2;
        nxt_st.idx_s1  = ENC0_C;
        nxt_st.idx_s2  = st_ff.idx_s1;
        gate_rise = st_ff.gate_s2 & ~st_ff.gate_q;
        mask = st_ff.lay_act.width16 ? MASK16 : MASK32;   // R12

        // Source of the processing cycle
        case (st_ff.lay_act.cycle_mode)
            FRAME_TRIGGERED_CYCLE:           cyc_start = FRAME_EVENT;    // R9
            CLOCK_SYNCHRONOUS_CYCLE:         cyc_start = SYNC_OUT_EVENT; // R10
            INPUT_ALIGNED_SYNCHRONOUS_CYCLE: cyc_start = SYNC_IN_EVENT;  // R11
            default:                         cyc_start = 1'b0;
        endcase
        nxt_st.cyc = cyc_start;

        // Latch: clearing the enable drops the flag, a capture wins
        if (!st_ff.ctrl[0].latch_en) begin
            nxt_st.latch_valid = 1'b0;
        end
        if (st_ff.cfg.gate_mode == GATE_LATCH && st_ff.ctrl[0].latch_en
            && gate_rise) begin
            nxt_st.latch_live  = ch_out[0].count;           // R4
            nxt_st.latch_valid = 1'b1;                      // R2
        end

        // Time of the last counted edge on channel 0
        if (ch_out[0].inc_edge) begin
            nxt_st.ts_live = DC_TIME;                       // R15
        end

        // Preset handshake and input image, taken at each cycle start
        for (int i = 0; i < 2; i++) begin
            nxt_st.load[i] = 1'b0;
            if (!st_ff.ctrl[i].set_counter) begin
                nxt_st.set_done[i] = 1'b0;
            end else if (cyc_start && !st_ff.set_done[i]) begin
                nxt_st.load[i]     = 1'b1;                  // R13
                nxt_st.set_done[i] = 1'b1;
            end
            if (cyc_start) begin
                nxt_st.cnt_img[i] = ch_out[i].count & mask; // R12
                case (st_ff.lay_act.opt_sel)
                    OPT_PERIOD:    nxt_st.opt_img[i] = ch_out[i].period; // R14
                    OPT_FREQUENCY: nxt_st.opt_img[i] = ch_out[i].freq;   // R14
                    default:       nxt_st.opt_img[i] = 32'h0;
                endcase
                nxt_st.status_img[i].set_done    = st_ff.set_done[i];
                nxt_st.status_img[i].period_over = ch_out[i].period_over;
                nxt_st.status_img[i].latch_valid =
                    (i == 0) ? st_ff.latch_valid : 1'b0;
                nxt_st.status_img[i].gate_level  =
                    (i == 0) ? st_ff.gate_s2 : 1'b0;
                nxt_st.status_img[i].index_level =
                    (i == 0) ? st_ff.idx_s2 : 1'b0;
            end
        end
        if (cyc_start) begin
            nxt_st.latch_img = st_ff.latch_live & mask;     // R12
            case (st_ff.lay_act.ts_sel)
                TS_64:   nxt_st.ts_img = st_ff.ts_live;     // R15
                TS_32:   nxt_st.ts_img = {32'h0, st_ff.ts_live[31:0]}; // R15
                default: nxt_st.ts_img = 64'h0;
            endcase
        end

        // APB: one wait-free access phase after each setup
        setup  = PSEL & ~PENABLE;
        access = PSEL & PENABLE & st_ff.pready;
        nxt_st.pready  = setup;
        nxt_st.pslverr = setup & ~hit;
        if (setup) begin
            nxt_st.prdata = rdata;
        end
        if (access && PWRITE && !st_ff.pslverr) begin
            case (PADDR)
                OFS_CONFIG: begin
                    nxt_st.cfg = config_t'(PWDATA[3:0]);    // R17
                end
                OFS_LAYOUT_PEND: begin
                    nxt_st.lay_pend = layout_t'(PWDATA[6:0]); // R18
                end
                OFS_RELOAD: begin
                    if (PWDATA[0]) begin
                        nxt_st.lay_act = st_ff.lay_pend;    // R18
                    end
                end
                OFS_CTRL0: begin
                    nxt_st.ctrl[0] = ctrl_t'(PWDATA[1:0]);  // R13
                end
                OFS_PRESET0: begin
                    nxt_st.preset[0] = PWDATA;              // R16
                end
                OFS_CTRL1: begin
                    nxt_st.ctrl[1] = ctrl_t'(PWDATA[1:0]);
                end
                OFS_PRESET1: begin
                    nxt_st.preset[1] = PWDATA;
                end
                default: begin
                    // Read-only words ignore writes
                end
            endcase
        end
    end

    // State register; reset loads constants only
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            st_ff          <= '0;
            st_ff.cfg      <= CONFIG_RESET;
            st_ff.lay_pend <= LAYOUT_RESET;
            st_ff.lay_act  <= LAYOUT_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign PRDATA      = st_ff.prdata;
    assign PREADY      = st_ff.pready;
    assign PSLVERR     = st_ff.pslverr;
    assign CYCLE_START = st_ff.cyc;

endmodule // quadrature_encoder_counter
`default_nettype wire

// ---- core/quadrature_encoder_counter_pkg.sv ----
`default_nettype none
package quadrature_encoder_counter_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFS_CONFIG      = 8'h00;
    localparam logic [7:0] OFS_LAYOUT_PEND = 8'h04;
    localparam logic [7:0] OFS_LAYOUT_ACT  = 8'h08;
    localparam logic [7:0] OFS_RELOAD      = 8'h0c;
    localparam logic [7:0] OFS_CTRL0       = 8'h10;
    localparam logic [7:0] OFS_PRESET0     = 8'h14;
    localparam logic [7:0] OFS_CTRL1       = 8'h18;
    localparam logic [7:0] OFS_PRESET1     = 8'h1c;
    localparam logic [7:0] OFS_STATUS0     = 8'h20;
    localparam logic [7:0] OFS_COUNT0      = 8'h24;
    localparam logic [7:0] OFS_LATCH0      = 8'h28;
    localparam logic [7:0] OFS_OPT0        = 8'h2c;
    localparam logic [7:0] OFS_TS_LO       = 8'h30;
    localparam logic [7:0] OFS_TS_HI       = 8'h34;
    localparam logic [7:0] OFS_STATUS1     = 8'h38;
    localparam logic [7:0] OFS_COUNT1      = 8'h3c;
    localparam logic [7:0] OFS_OPT1        = 8'h40;

    // Counter width masks
    localparam logic [31:0] MASK16 = 32'h0000ffff;
    localparam logic [31:0] MASK32 = 32'hffffffff;

    // Timing: clock, period resolution, period ranges, frequency window
    localparam int    CLK_PERIOD_NS      = 100;
    localparam int    PERIOD_UNIT_NS     = 100;
    localparam int    PERIOD_UNIT_CYCLES =
        (PERIOD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint PERIOD_SHORT_NS   = 64'd1600000000;
    localparam longint PERIOD_LONG_NS    = 64'd3200000000;
    localparam int    PERIOD_SHORT_UNITS = int'(PERIOD_SHORT_NS / PERIOD_UNIT_NS);
    localparam int    PERIOD_LONG_UNITS  = int'(PERIOD_LONG_NS / PERIOD_UNIT_NS);
    localparam longint FREQ_WINDOW_NS    = 64'd1000000000;
    localparam int    FREQ_WINDOW_CYCLES = int'(FREQ_WINDOW_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        GATE_OFF       = 2'b00,
        GATE_HALT_HIGH = 2'b01,
        GATE_HALT_LOW  = 2'b10,
        GATE_LATCH     = 2'b11
    } gate_mode_t;

    typedef enum logic [1:0] {
        FRAME_TRIGGERED_CYCLE           = 2'b00,
        CLOCK_SYNCHRONOUS_CYCLE         = 2'b01,
        INPUT_ALIGNED_SYNCHRONOUS_CYCLE = 2'b10
    } cycle_mode_t;

    typedef enum logic [1:0] {
        OPT_NONE = 2'b00, OPT_PERIOD = 2'b01, OPT_FREQUENCY = 2'b10
    } opt_sel_t;

    typedef enum logic [1:0] {
        TS_NONE = 2'b00, TS_64 = 2'b01, TS_32 = 2'b10
    } ts_sel_t;

    typedef struct packed {
        cycle_mode_t cycle_mode;
        ts_sel_t     ts_sel;
        opt_sel_t    opt_sel;
        logic        width16;
    } layout_t;

    typedef struct packed {
        logic       period_long;
        logic       single_track;
        gate_mode_t gate_mode;
    } config_t;

    typedef struct packed {
        logic latch_en;
        logic set_counter;
    } ctrl_t;

    typedef struct packed {
        logic index_level;
        logic period_over;
        logic gate_level;
        logic latch_valid;
        logic set_done;
    } status_t;

    typedef struct packed {
        logic [31:0] count;
        logic [31:0] period;
        logic        period_over;
        logic [31:0] freq;
        logic        inc_edge;
    } chan_out_t;

    // Values after reset
    localparam config_t CONFIG_RESET = 4'h0;
    localparam layout_t LAYOUT_RESET = 7'h00;

endpackage
`default_nettype wire
